// [inc/arp_defs.vh]
`ifndef ARP_DEFS_VH
`define ARP_DEFS_VH
// Functional notes
// - With interface select high, the host holds the upper result pins at digital ground.
// - Interface select high with byte select low chooses the serial interface.
// - Interface select high with byte select high chooses parallel byte mode.
// - In byte mode the bit-14 pin is driven by the host; high sends the high byte first, low the low byte first.
// - In byte mode each 14-bit result comes over the low eight pins in two read strobes.

// Register offsets (byte addresses)
`define ARP_OFS_CTRL   8'h00
`define ARP_OFS_STAT   8'h04
`define ARP_OFS_DATA   8'h08
// Control register fields
`define ARP_CTRL_START 0
`define ARP_CTRL_MODE  1
`define ARP_CTRL_HBF   3
`define ARP_CTRL_REF   4
`define ARP_CTRL_CNT   8
`define ARP_CTRL_RST   32'h0000_0000
// Modes
`define ARP_MODE_PAR   2'h0
`define ARP_MODE_BYTE  2'h1
`define ARP_MODE_SER   2'h2
// Timing: half period of read strobe and serial clock
`define ARP_CLK_MHZ    20
`define ARP_HALF_NS    200
`define ARP_HALF_CYC   ((`ARP_HALF_NS * `ARP_CLK_MHZ + 999) / 1000)
`define ARP_SER_BITS   14
`define ARP_FIFO_DEPTH 8
`endif

// [verif/arp_dev_model.sv]
module arp_dev_model (
  input  wire [13:0] res,    // Result the converter presents
  input  wire        cs_n,   // Chip select, active low
  input  wire        rd_sclk,// Read strobe or serial clock
  input  wire        isel,   // Interface select strap
  input  wire        ref_sel,// Reference select
  input  wire [4:0]  up_out, // Host drive, bits 13..9
  input  wire        up_oe,  // Host enable, bits 13..9
  input  wire        a_out,  // Host drive, bit 14 pin
  input  wire        a_oe,   // Host enable, bit 14 pin
  input  wire        b_out,  // Host drive, bit 15 pin
  input  wire        b_oe,   // Host enable, bit 15 pin
  output wire [6:0]  lo,     // Bits 6..0 level
  output wire        b7,     // Bit 7 or line A level
  output wire        b8,     // Bit 8 or line B level
  output wire [4:0]  up_in,  // Bits 13..9 level
  output wire        a_in,   // Bit 14 level
  output wire        b_in    // Bit 15 level
);
  timeunit 1ns;
  timeprecision 1ns;
  reg  [3:0]  idx = 4'd13;    // Serial bit position
  reg         second = 1'b0;  // Byte phase
  // Undriven straps read low, so with isel high and the B pin released the model is in serial mode
  wire        bsel = b_oe ? b_out : 1'b0;
  wire        hbf = a_oe ? a_out : 1'b0;
  wire        byte_m = isel & bsel;
  wire        ser_m = isel & ~bsel;
  wire        int_ref = ref_sel;  // No effect on data
  wire [15:0] word = {res[13], res[13], res};
  wire [7:0]  hi_b = {res[13], res[13], res[13:8]};
  wire [7:0]  cur = (second ^ hbf) ? hi_b : res[7:0];
  wire        en = ~cs_n & (ser_m | ~rd_sclk);
  wire [15:0] d = ser_m ? {7'h00, ~res[idx], res[idx], 7'h00}
                : byte_m ? {8'h00, cur} : word;
  // Released lines show the inverse, never the last value
  wire [15:0] q = en ? d : ~d;
  assign lo = q[6:0];
  assign b7 = q[7];
  assign b8 = q[8];
  assign up_in = up_oe ? up_out : q[13:9];
  assign a_in = a_oe ? a_out : q[14];
  assign b_in = b_oe ? b_out : q[15];
  // Frame end rewinds, so the next falling select shows the MSB and
  // the first byte; one process keeps a single driver per variable
  always @(posedge cs_n or posedge rd_sclk) begin
    if (cs_n) begin
      idx <= 4'd13;
      second <= 1'b0;
    end else begin
      idx <= (idx == 4'd0) ? 4'd13 : idx - 4'd1;
      second <= ~second;
    end
  end
endmodule

// [verif/arp_host_asserts.sv]
module arp_host_asserts (
  input wire       hclk,                     // System clock
  input wire       hresetn,                  // Reset, active low
  input wire       hreadyout,                // Slave ready
  input wire       hresp,                    // Slave response
  input wire       cs_n,                     // Chip select, active low
  input wire       rd_sclk,                  // Strobe or serial clock
  input wire       interface_select,         // Mode strap
  input wire [4:0] result_upper_bits_out,    // Ground level drive
  input wire       result_upper_bits_oe,     // Ground drive enable
  input wire       sign_extension_bit_a_oe,  // Order pin enable
  input wire       sign_extension_bit_b_out, // Byte select level
  input wire       sign_extension_bit_b_oe   // Byte select enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Zero wait states, always OKAY
  property p_bus_ok; hreadyout && !hresp; endproperty
  // Past value guards the one strap cycle after a mode write
  property p_upper_gnd; interface_select && $past(interface_select)
    |-> result_upper_bits_oe && result_upper_bits_out == 5'h00; endproperty
  property p_par_float; !interface_select && !$past(interface_select)
    |-> !result_upper_bits_oe && !sign_extension_bit_a_oe
        && !sign_extension_bit_b_oe; endproperty
  property p_strap_drv; interface_select && $past(interface_select)
    |-> sign_extension_bit_b_oe && sign_extension_bit_a_oe; endproperty
  property p_idle_high; cs_n |-> rd_sclk; endproperty
  property p_cs_lead; $fell(cs_n) |-> rd_sclk [*4]; endproperty
  property p_low_len; $fell(rd_sclk) |-> !rd_sclk [*4] ##1 rd_sclk;
  endproperty
  property p_high_gap; $rose(rd_sclk) && !cs_n |-> rd_sclk [*4];
  endproperty

  a_bus_ok: assert property (p_bus_ok)
    else $error("bus answer not ready or not okay");
  a_upper_gnd: assert property (p_upper_gnd)
    else $error("upper pins not grounded");
  a_par_float: assert property (p_par_float)
    else $error("host drives pins in parallel mode");
  a_strap_drv: assert property (p_strap_drv)
    else $error("mode straps not driven");
  a_idle_high: assert property (p_idle_high)
    else $error("strobe low outside frame");
  a_cs_lead: assert property (p_cs_lead)
    else $error("strobe too soon after select");
  a_low_len: assert property (p_low_len)
    else $error("strobe low phase length wrong");
  a_high_gap: assert property (p_high_gap)
    else $error("strobe high phase too short");

  c_par: cover property ($fell(rd_sclk) && !interface_select);
  c_byte: cover property ($fell(rd_sclk) && interface_select
    && sign_extension_bit_b_out);
  c_ser: cover property ($fell(rd_sclk) && interface_select
    && !sign_extension_bit_b_out);
endmodule

// [verif/tb_top.sv]
`include "arp_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [13:0] res;
  wire  [31:0] hrdata;
  wire  [6:0]  lo;
  wire  [4:0]  up_in, up_out;
  wire         hreadyout, hresp, cs_n, rd_sclk, isel, ref_sel, b7, b8;
  wire         up_oe, a_in, a_out, a_oe, b_in, b_out, b_oe;
  int          n_fail, check_count;

  arp_host arp_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cs_n(cs_n), .rd_sclk(rd_sclk),
    .interface_select(isel), .ref_select(ref_sel), .low_bits_in(lo),
    .bit7_or_serial_line_a(b7), .bit8_or_serial_line_b(b8),
    .result_upper_bits_in(up_in), .result_upper_bits_out(up_out),
    .result_upper_bits_oe(up_oe), .sign_extension_bit_a_in(a_in),
    .sign_extension_bit_a_out(a_out), .sign_extension_bit_a_oe(a_oe),
    .sign_extension_bit_b_in(b_in), .sign_extension_bit_b_out(b_out),
    .sign_extension_bit_b_oe(b_oe));
  arp_dev_model arp_dev_model_i (.res(res), .cs_n(cs_n), .rd_sclk(rd_sclk),
    .isel(isel), .ref_sel(ref_sel), .up_out(up_out), .up_oe(up_oe),
    .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .lo(lo),
    .b7(b7), .b8(b8), .up_in(up_in), .a_in(a_in), .b_in(b_in));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for the next edge with ready high
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_fail++;
        give_verdict;
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask

  // Sign extension the converter applies in parallel and byte modes, the host in serial
  function automatic logic [31:0] sx(input logic [13:0] x);
    return {16'h0000, x[13], x[13], x};
  endfunction

  // One conversion run; expects A then B words in serial mode
  task automatic run(input logic [1:0] m, input logic hb,
                     input logic [3:0] cnt);
    logic        r;
    logic [31:0] c;
    int          n, w;
    r = 1'($urandom);
    c = {20'h00000, cnt, 3'h0, r, hb, m, 1'b1};
    bus(1'b1, `ARP_OFS_CTRL, c, v);
    // Start lands at the end of the data phase, straps one cycle later
    repeat (3) @(posedge hclk);
    chk(ref_sel, r);
    chk(isel, m != `ARP_MODE_PAR);
    if (m == `ARP_MODE_BYTE) chk({b_out, a_out}, {1'b1, hb});
    if (m == `ARP_MODE_SER) chk(b_out, 1'b0);
    // Settings read back; the start bit always reads zero
    bus(1'b0, `ARP_OFS_CTRL, 32'h0, v);
    chk(v, c & 32'hffff_fffe);
    n = 0;
    do begin
      bus(1'b0, `ARP_OFS_STAT, 32'h0, v);
      n++;
    end while (v[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      n_fail++;
      give_verdict;
    end
    w = (cnt + 1) * ((m == `ARP_MODE_SER) ? 2 : 1);
    chk(v[7:4], w[3:0]);
    chk(v[2], w == 8);
    chk(v[1], 1'b1);
    for (int i = 0; i < w; i++) begin
      bus(1'b0, `ARP_OFS_DATA, 32'h0, v);
      chk(v, (m == `ARP_MODE_SER && i[0]) ? sx(~res) : sx(res));
    end
    bus(1'b0, `ARP_OFS_DATA, 32'h0, v);
    chk(v, 32'h0);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    res = 14'h0000;
    void'($urandom(88));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({cs_n, rd_sclk, isel, ref_sel, up_oe, a_oe, b_oe}, 7'h60);
    // Random words in every mode and both byte orders
    for (int k = 0; k < 6; k++) begin
      res <= 14'($urandom);
      run(2'(k % 3), k > 2, 4'($urandom_range(3)));
      $display("test %0d done", k);
    end
    // Corner words; both eight-word runs (parallel and serial) fill the buffer
    res <= 14'h2000;
    run(`ARP_MODE_PAR, 1'b0, 4'h7);
    res <= 14'h1fff;
    run(`ARP_MODE_BYTE, 1'b1, 4'h0);
    res <= 14'h2001;
    run(`ARP_MODE_SER, 1'b0, 4'h3);
    $display("test corners done");
    bus(1'b0, 8'h0c, 32'h0, v);
    chk(v, 32'h0);
    $display("test unmapped done");
    give_verdict;
  end
endmodule

bind arp_host arp_host_asserts arp_host_asserts_i (.*);

// [verilog/arp_fifo.v]
module arp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,       // System clock
  input  wire             rst_n,     // Async reset, active low
  input  wire             in_valid,  // Write request
  output wire             in_ready,  // Space available
  input  wire [WIDTH-1:0] in_data,   // Write word
  output wire             out_valid, // Word available
  input  wire             out_ready, // Read request
  output wire [WIDTH-1:0] out_data,  // Head word
  output wire [AW:0]      level      // Words held
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ff;
  reg [AW-1:0]    rd_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;

  // Honest flags straight from the count
  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ff];
  assign level     = cnt_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage has no reset; only pointers and count need defined values
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// [verilog/arp_host.v]
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`include "arp_defs.vh"
module arp_host (
  input  wire        hclk,                  // System clock, 20 MHz
  input  wire        hresetn,               // Async reset, active low
  input  wire        hsel,                  // Slave select
  input  wire [31:0] haddr,                 // Address
  input  wire [1:0]  htrans,                // Transfer type
  input  wire        hwrite,                // Write when high
  input  wire [2:0]  hsize,                 // Transfer size
  input  wire [31:0] hwdata,                // Write data
  input  wire        hready,                // Bus ready
  output reg  [31:0] hrdata,                // Read data
  output reg         hreadyout,             // Slave ready
  output reg         hresp,                 // Always OKAY
  output reg         cs_n,                  // Chip select, active low
  output reg         rd_sclk,               // Read strobe or serial clock
  output reg         interface_select,      // Low parallel, high byte/serial
  output reg         ref_select,            // High internal reference
  input  wire [6:0]  low_bits_in,           // Result bits 6..0
  input  wire        bit7_or_serial_line_a, // Bit 7 or serial line A
  input  wire        bit8_or_serial_line_b, // Bit 8 or serial line B
  input  wire [4:0]  result_upper_bits_in,  // Result bits 13..9
  output reg  [4:0]  result_upper_bits_out, // Ground level drive
  output reg         result_upper_bits_oe,  // High while host drives
  input  wire        sign_extension_bit_a_in,  // Bit 14 pin level
  output reg         sign_extension_bit_a_out, // Byte order select
  output reg         sign_extension_bit_a_oe,  // High while host drives
  input  wire        sign_extension_bit_b_in,  // Bit 15 pin level
  output reg         sign_extension_bit_b_out, // Byte mode select
  output reg         sign_extension_bit_b_oe   // High while host drives
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_PLO  = 3'h1;
  localparam [2:0] S_PHI  = 3'h2;
  localparam [2:0] S_SHI  = 3'h3;
  localparam [2:0] S_SLO  = 3'h4;
  localparam [2:0] S_PUSH = 3'h5;
  localparam [2:0] S_END  = 3'h6;
  localparam integer HALF_I   = `ARP_HALF_CYC - 1;
  localparam integer LAST_I   = `ARP_SER_BITS - 1;
  // Counts fit four bits, so the upper bits are cut on purpose
  localparam [3:0]   HALF_M1  = HALF_I[3:0];
  localparam [3:0]   LAST_BIT = LAST_I[3:0];

  reg  [15:0] sync1_ff;
  reg  [15:0] sync2_ff;
  reg  [1:0]  mode_ff;
  reg         hbf_ff;
  reg         ref_ff;
  reg  [3:0]  cnt_cfg_ff;
  reg         start_ff;
  reg         wr_pend_ff;
  reg  [7:0]  wr_addr_ff;
  reg  [2:0]  state_ff;
  reg  [3:0]  tmr_ff;
  reg  [3:0]  bit_ff;
  reg  [3:0]  words_ff;
  reg         phase_ff;
  reg  [7:0]  byte_ff;
  reg  [13:0] sh_a_ff;
  reg  [13:0] sh_b_ff;
  reg         pend_b_ff;
  reg  [15:0] word_ff;
  reg         push_ff;
  wire        in_ready;
  wire        out_valid;
  wire [15:0] out_data;
  wire [3:0]  level;
  wire        addr_ph;
  wire        pop_req;
  wire [7:0]  cur_byte;
  wire [7:0]  hi_byte;
  wire [7:0]  lo_byte;
  wire        busy;

  assign addr_ph  = hsel & htrans[1] & hready;
  assign pop_req  = addr_ph & ~hwrite & (haddr[7:0] == `ARP_OFS_DATA);
  assign busy     = (state_ff != S_IDLE);
  assign cur_byte = sync2_ff[7:0];
  assign hi_byte  = hbf_ff ? byte_ff : cur_byte;
  assign lo_byte  = hbf_ff ? cur_byte : byte_ff;

  // Results wait here; a full buffer stalls the read sequence
  arp_fifo #(
    .WIDTH (16),
    .DEPTH (`ARP_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (push_ff),
    .in_ready  (in_ready),
    .in_data   (word_ff),
    .out_valid (out_valid),
    .out_ready (pop_req),
    .out_data  (out_data),
    .level     (level)
  );

  // Two-stage synchroniser for all data pins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
    end else begin
      sync1_ff <= {sign_extension_bit_b_in, sign_extension_bit_a_in,
                   result_upper_bits_in, bit8_or_serial_line_b,
                   bit7_or_serial_line_a, low_bits_in};
      sync2_ff <= sync1_ff;
    end
  end

  // Bus slave: zero wait states, read data set up in address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      mode_ff    <= `ARP_MODE_PAR;
      hbf_ff     <= 1'b0;
      ref_ff     <= 1'b0;
      cnt_cfg_ff <= 4'h0;
      start_ff   <= 1'b0;
    end else begin
      start_ff   <= 1'b0;
      wr_pend_ff <= addr_ph & hwrite;
      if (addr_ph) begin
        wr_addr_ff <= haddr[7:0];
      end
      if (addr_ph & ~hwrite) begin
        case (haddr[7:0])
          `ARP_OFS_CTRL: hrdata <= {20'h00000, cnt_cfg_ff, 3'h0, ref_ff,
                                    hbf_ff, mode_ff, 1'b0};
          `ARP_OFS_STAT: hrdata <= {24'h000000, level, 1'b0, ~in_ready,
                                    out_valid, busy};
          `ARP_OFS_DATA: hrdata <= out_valid ? {16'h0000, out_data}
                                             : 32'h0000_0000;
          default:       hrdata <= 32'h0000_0000;
        endcase
      end
      // Settings only change while idle, so a run never sees a mode flip
      if (wr_pend_ff && wr_addr_ff == `ARP_OFS_CTRL && !busy) begin
        mode_ff    <= hwdata[`ARP_CTRL_MODE+1:`ARP_CTRL_MODE];
        hbf_ff     <= hwdata[`ARP_CTRL_HBF];
        ref_ff     <= hwdata[`ARP_CTRL_REF];
        cnt_cfg_ff <= hwdata[`ARP_CTRL_CNT+3:`ARP_CTRL_CNT];
        start_ff   <= hwdata[`ARP_CTRL_START];
      end
    end
  end

  // Mode straps driven onto the shared pins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interface_select         <= 1'b0;
      ref_select               <= 1'b0;
      result_upper_bits_out    <= 5'h00;
      result_upper_bits_oe     <= 1'b0;
      sign_extension_bit_a_out <= 1'b0;
      sign_extension_bit_a_oe  <= 1'b0;
      sign_extension_bit_b_out <= 1'b0;
      sign_extension_bit_b_oe  <= 1'b0;
    end else begin
      interface_select <= (mode_ff == `ARP_MODE_BYTE) |
                          (mode_ff == `ARP_MODE_SER);
      ref_select       <= ref_ff;
      result_upper_bits_out <= 5'h00;
      result_upper_bits_oe  <= (mode_ff == `ARP_MODE_BYTE) |
                               (mode_ff == `ARP_MODE_SER);
      sign_extension_bit_b_out <= (mode_ff == `ARP_MODE_BYTE);
      sign_extension_bit_b_oe  <= (mode_ff == `ARP_MODE_BYTE) |
                                  (mode_ff == `ARP_MODE_SER);
      sign_extension_bit_a_out <= (mode_ff == `ARP_MODE_BYTE) & hbf_ff;
      sign_extension_bit_a_oe  <= (mode_ff == `ARP_MODE_BYTE) |
                                  (mode_ff == `ARP_MODE_SER);
    end
  end

  // Read sequencer; strobe idles high, samples taken late in low phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff  <= S_IDLE;
      cs_n      <= 1'b1;
      rd_sclk   <= 1'b1;
      tmr_ff    <= 4'h0;
      bit_ff    <= 4'h0;
      words_ff  <= 4'h0;
      phase_ff  <= 1'b0;
      byte_ff   <= 8'h00;
      sh_a_ff   <= 14'h0000;
      sh_b_ff   <= 14'h0000;
      pend_b_ff <= 1'b0;
      word_ff   <= 16'h0000;
      push_ff   <= 1'b0;
    end else begin
      if (tmr_ff != 4'h0) begin
        tmr_ff <= tmr_ff - 1'b1;
      end
      case (state_ff)
        S_IDLE: begin
          if (start_ff) begin
            cs_n     <= 1'b0;
            words_ff <= cnt_cfg_ff;
            phase_ff <= 1'b0;
            bit_ff   <= 4'h0;
            tmr_ff   <= HALF_M1;
            state_ff <= (mode_ff == `ARP_MODE_SER) ? S_SHI : S_PHI;
          end
        end
        S_PHI: begin
          if (tmr_ff == 4'h0) begin
            rd_sclk  <= 1'b0;
            tmr_ff   <= HALF_M1;
            state_ff <= S_PLO;
          end
        end
        S_PLO: begin
          if (tmr_ff == 4'h0) begin
            rd_sclk <= 1'b1;
            tmr_ff  <= HALF_M1;
            if (mode_ff == `ARP_MODE_BYTE && !phase_ff) begin
              byte_ff  <= cur_byte;
              phase_ff <= 1'b1;
              state_ff <= S_PHI;
            end else begin
              if (mode_ff == `ARP_MODE_BYTE) begin
                word_ff <= {hi_byte[5], hi_byte[5], hi_byte[5:0], lo_byte};
              end else begin
                word_ff <= sync2_ff;
              end
              phase_ff <= 1'b0;
              push_ff  <= 1'b1;
              state_ff <= S_PUSH;
            end
          end
        end
        S_SHI: begin
          if (tmr_ff == 4'h0) begin
            rd_sclk  <= 1'b0;
            tmr_ff   <= HALF_M1;
            state_ff <= S_SLO;
          end
        end
        S_SLO: begin
          if (tmr_ff == 4'h0) begin
            rd_sclk <= 1'b1;
            tmr_ff  <= HALF_M1;
            sh_a_ff <= {sh_a_ff[12:0], sync2_ff[7]};
            sh_b_ff <= {sh_b_ff[12:0], sync2_ff[8]};
            if (bit_ff == LAST_BIT) begin
              bit_ff    <= 4'h0;
              word_ff   <= {sh_a_ff[12], sh_a_ff[12], sh_a_ff[12:0],
                            sync2_ff[7]};
              pend_b_ff <= 1'b1;
              push_ff   <= 1'b1;
              state_ff  <= S_PUSH;
            end else begin
              bit_ff   <= bit_ff + 1'b1;
              state_ff <= S_SHI;
            end
          end
        end
        S_PUSH: begin
          // Holds until the buffer has room, which back-pressures the link
          if (push_ff && in_ready) begin
            push_ff <= 1'b0;
            if (pend_b_ff) begin
              pend_b_ff <= 1'b0;
              push_ff   <= 1'b1;
              word_ff   <= {sh_b_ff[13], sh_b_ff[13], sh_b_ff};
            end else if (words_ff == 4'h0) begin
              tmr_ff   <= HALF_M1;
              state_ff <= S_END;
            end else begin
              words_ff <= words_ff - 1'b1;
              tmr_ff   <= HALF_M1;
              state_ff <= (mode_ff == `ARP_MODE_SER) ? S_SHI : S_PHI;
            end
          end
        end
        S_END: begin
          if (tmr_ff == 4'h0) begin
            cs_n     <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule
